/* src/tps_lfsr.sv */
// Shift register behind every pseudo-random and derived sequence.
// Assumes degree and extend only change together with load.
module tps_lfsr
  import tps_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // Control
  input wire logic load,
  input wire logic extend,
  input wire logic [4:0] degree,
  // State, newest bit in bit 0
  output logic [TPS_POS_W-1:0] state
);

  function automatic logic [30:0] tapMask(logic [4:0] d);
    case (d)
      TPS_DEG31: tapMask = TPS_TAPS31;
      TPS_DEG23: tapMask = TPS_TAPS23;
      TPS_DEG15: tapMask = TPS_TAPS15;
      TPS_DEG13: tapMask = TPS_TAPS13;
      TPS_DEG11: tapMask = TPS_TAPS11;
      TPS_DEG10: tapMask = TPS_TAPS10;
      default: tapMask = TPS_TAPS7;
    endcase
  endfunction : tapMask

  wire logic [30:0] lowMask = (31'h1 << 5'(degree - 5'h1)) - 31'h1;
  wire logic [30:0] fullMask = (31'h1 << degree) - 31'h1;
  wire logic lowZero = (state & lowMask) == '0;
  // Extended mode also visits the all-zero state: one more zero in the
  // longest run, and no lock-up state left
  wire logic fb = (^(state & tapMask(degree))) ^ (extend && lowZero);
  wire logic [30:0] shifted = {state[29:0], fb} & fullMask;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= '0;
    else if (en)
      state <= load ? (extend ? TPS_SEED_EXT : TPS_SEED_PLAIN) : shifted;
  end

  property p_no_lockup;
    @(posedge clk) disable iff (!nrst)
    (en && !load && !extend && state != '0) |=> state != '0;
  endproperty
  a_no_lockup: assert property (p_no_lockup)
    else $error("plain sequence fell into the zero state");

endmodule : tps_lfsr

/* src/tps_pat_mem.sv */
// Bit-wide store for the four RAM-resident user patterns.
// Assumes the loader writes on the same clock; read data one cycle late.
module tps_pat_mem
  import tps_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // Write side
  input wire tps_mwr_s wr,
  // Read side
  input wire logic [TPS_MEM_AW-1:0] rdAddr,
  output logic rdData
);

  logic mem [0:TPS_MEM_DEPTH-1];

  always_ff @(posedge clk)
  begin
    if (en && wr.we)
      mem[{wr.slot, wr.addr}] <= wr.data;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdData <= 1'b0;
    else if (en)
      rdData <= mem[rdAddr];
  end

endmodule : tps_pat_mem

/* src/tps_pkg.sv */
// Constants, types and helpers of the test pattern selector.
// Assumes one bit clock shared by every block that talks to it.
package tps_pkg;

  // Widths
  localparam int TPS_POS_W = 31;
  localparam int TPS_LEN_W = 23;
  localparam int TPS_RUN_W = 13;
  localparam int TPS_RAM_AW = 13;
  localparam int TPS_MEM_AW = 15;
  localparam int TPS_EXT_AW = 22;
  localparam int TPS_MEM_DEPTH = 32768;

  // Pattern length limits in bits
  localparam logic [22:0] TPS_USER_MAX = 23'h400000;
  localparam logic [22:0] TPS_RAM_MAX = 23'h002000;

  // User pattern numbers
  localparam logic [3:0] TPS_CURRENT = 4'h0;
  localparam logic [3:0] TPS_RAM_FIRST = 4'h1;
  localparam logic [3:0] TPS_RAM_LAST = 4'h4;
  localparam logic [3:0] TPS_DISC_FIRST = 4'h5;
  localparam logic [3:0] TPS_DISC_LAST = 4'hc;

  // Shift register degrees and feedback tap masks
  localparam logic [4:0] TPS_DEG31 = 5'h1f;
  localparam logic [4:0] TPS_DEG23 = 5'h17;
  localparam logic [4:0] TPS_DEG15 = 5'h0f;
  localparam logic [4:0] TPS_DEG13 = 5'h0d;
  localparam logic [4:0] TPS_DEG11 = 5'h0b;
  localparam logic [4:0] TPS_DEG10 = 5'h0a;
  localparam logic [4:0] TPS_DEG7 = 5'h07;
  localparam logic [30:0] TPS_TAPS31 = 31'h48000000;
  localparam logic [30:0] TPS_TAPS23 = 31'h00420000;
  localparam logic [30:0] TPS_TAPS15 = 31'h00006000;
  localparam logic [30:0] TPS_TAPS13 = 31'h00001c80;
  localparam logic [30:0] TPS_TAPS11 = 31'h00000500;
  localparam logic [30:0] TPS_TAPS10 = 31'h00000240;
  localparam logic [30:0] TPS_TAPS7 = 31'h00000060;
  localparam logic [30:0] TPS_SEED_PLAIN = 31'h00000001;
  localparam logic [30:0] TPS_SEED_EXT = 31'h00000000;

  typedef enum logic [3:0] {
    TPS_PRBS31 = 4'h0, TPS_PRBS23 = 4'h1, TPS_PRBS15 = 4'h2,
    TPS_PRBS10 = 4'h3, TPS_PRBS7 = 4'h4, TPS_USER = 4'h5,
    TPS_ZRUN13 = 4'h6, TPS_ZRUN11 = 4'h7, TPS_ZRUN10 = 4'h8,
    TPS_ZRUN7 = 4'h9, TPS_ONES13 = 4'ha, TPS_ONES11 = 4'hb,
    TPS_ONES10 = 4'hc, TPS_ONES7 = 4'hd, TPS_ALTWORD = 4'he,
    TPS_ALTPAT = 4'hf
  } tps_sel_e;

  typedef enum logic [2:0] {
    TPS_RATIO_1_8 = 3'h0, TPS_RATIO_1_4 = 3'h1, TPS_RATIO_1_2 = 3'h2,
    TPS_RATIO_3_4 = 3'h3, TPS_RATIO_7_8 = 3'h4
  } tps_ratio_e;

  typedef enum logic [1:0] {
    TPS_SRC_LFSR = 2'h0, TPS_SRC_RAM = 2'h1, TPS_SRC_EXT = 2'h2
  } tps_src_e;

  typedef logic [15:0] tps_selmask_t;
  localparam tps_selmask_t TPS_MASTER_MASK = 16'h3fff;

  typedef struct packed {
    tps_sel_e sel;
    logic [3:0] userNum;
    logic [22:0] userLen;
    logic [12:0] zeroRun;
    tps_ratio_e ratio;
  } tps_cfg_s;

  typedef struct packed {
    logic we;
    logic [1:0] slot;
    logic [12:0] addr;
    logic data;
  } tps_mwr_s;

  localparam tps_cfg_s TPS_CFG_RESET = '{sel: TPS_PRBS31,
    userNum: 4'h1, userLen: 23'h000001, zeroRun: 13'h0001,
    ratio: TPS_RATIO_1_2};

  function automatic logic [4:0] tps_deg(tps_sel_e s);
    case (s)
      TPS_PRBS31: tps_deg = TPS_DEG31;
      TPS_PRBS23: tps_deg = TPS_DEG23;
      TPS_PRBS15: tps_deg = TPS_DEG15;
      TPS_PRBS10, TPS_ZRUN10, TPS_ONES10: tps_deg = TPS_DEG10;
      TPS_ZRUN13, TPS_ONES13: tps_deg = TPS_DEG13;
      TPS_ZRUN11, TPS_ONES11: tps_deg = TPS_DEG11;
      default: tps_deg = TPS_DEG7;
    endcase
  endfunction : tps_deg

  function automatic logic tps_is_zrun(tps_sel_e s);
    return (s >= TPS_ZRUN13) && (s <= TPS_ZRUN7);
  endfunction : tps_is_zrun

  function automatic logic tps_is_ones(tps_sel_e s);
    return (s >= TPS_ONES13) && (s <= TPS_ONES7);
  endfunction : tps_is_ones

  function automatic logic tps_is_user(tps_sel_e s);
    return (s == TPS_USER) || (s == TPS_ALTWORD) || (s == TPS_ALTPAT);
  endfunction : tps_is_user

  function automatic logic [30:0] tps_len(tps_cfg_s c);
    if (tps_is_user(c.sel))
      return {8'h00, c.userLen};
    else if (tps_is_zrun(c.sel) || tps_is_ones(c.sel))
      return 31'h1 << tps_deg(c.sel);
    else
      return (31'h1 << tps_deg(c.sel)) - 31'h1;
  endfunction : tps_len

endpackage : tps_pkg

/* src/tps_selector.sv */
// Test pattern selector: picks and plays the reference bit stream that
// the error detector compares with the received data.
// Assumes configuration, loader and external pattern store run on clk;
// the store answers an address one cycle later.
module tps_selector
  import tps_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // Pattern choice
  input wire tps_cfg_s cfg,
  input wire logic cfgLoad,
  input wire logic slaveMode,
  input wire tps_selmask_t companionMask,
  // User pattern loading
  input wire tps_mwr_s memWr,
  // External pattern store
  output logic [TPS_EXT_AW-1:0] extAddr,
  input wire logic extData,
  // Reference stream
  output logic refBit,
  output logic refValid,
  output logic refStart,
  // Status
  output logic cfgReject,
  output tps_selmask_t offered,
  output tps_sel_e activeSel
);

  tps_cfg_s actCfg;
  logic run;
  logic [TPS_POS_W-1:0] posCnt;
  logic [TPS_POS_W-1:0] lfsrState;
  logic memQ;
  logic s1Bit;
  logic s1Start;
  logic s1Valid;
  tps_src_e s1Src;
  logic [TPS_RUN_W-1:0] s1Pos;
  logic onesBit;

  function automatic logic tapAt(logic [30:0] s, logic [4:0] d,
                                 logic [4:0] back);
    return s[5'(d - back)];
  endfunction : tapAt

  function automatic logic inRange(logic [3:0] n, logic [3:0] lo,
                                   logic [3:0] hi);
    return (n >= lo) && (n <= hi);
  endfunction : inRange

  // Offer set follows the companion exactly when slaved
  wire tps_selmask_t offerNow = slaveMode ? companionMask
                                          : TPS_MASTER_MASK;

  // Check of a requested selection
  wire logic [3:0] num = cfg.userNum;
  wire logic numRam = inRange(num, TPS_RAM_FIRST, TPS_RAM_LAST);
  wire logic numExt = (num == TPS_CURRENT)
                      || inRange(num, TPS_DISC_FIRST, TPS_DISC_LAST);
  wire logic lenSet = cfg.userLen != '0;
  wire logic ramLenOk = numRam && (cfg.userLen <= TPS_RAM_MAX);
  wire logic extLenOk = numExt && (cfg.userLen <= TPS_USER_MAX);
  wire logic userOk = !tps_is_user(cfg.sel)
                      || (lenSet && (ramLenOk || extLenOk));
  wire logic [30:0] cfgLen = tps_len(cfg);
  wire logic runOk = !tps_is_zrun(cfg.sel)
                     || ({18'h0, cfg.zeroRun} < cfgLen);
  wire logic ratioOk = !tps_is_ones(cfg.sel)
                       || (cfg.ratio <= TPS_RATIO_7_8);
  wire logic legal = offerNow[cfg.sel] && userOk && runOk && ratioOk;
  wire logic accept = cfgLoad && legal;

  // A rejected request leaves the running pattern untouched; the
  // first cycle after reset starts the default sequence
  wire logic restart = accept || !run;
  wire tps_cfg_s loadCfg = accept ? cfg : actCfg;
  wire logic loadExt = tps_is_zrun(loadCfg.sel) || tps_is_ones(loadCfg.sel);

  // Position within the period
  wire logic [4:0] deg = tps_deg(actCfg.sel);
  wire logic [30:0] lastPos = tps_len(actCfg) - 31'h1;
  wire logic wrap = posCnt == lastPos;
  wire logic [30:0] next_posCnt = (restart || wrap) ? '0
                                  : posCnt + 31'h1;

  // Sequence generator
  tps_lfsr u_lfsr (
    .clk(clk),
    .nrst(nrst),
    .en(en),
    .load(restart),
    .extend(loadExt),
    .degree(tps_deg(loadCfg.sel)),
    .state(lfsrState)
  );

  // Three next-leaving bits of the register
  wire logic b0 = tapAt(lfsrState, deg, 5'h1);
  wire logic b1 = tapAt(lfsrState, deg, 5'h2);
  wire logic b2 = tapAt(lfsrState, deg, 5'h3);

  // Every 3-bit window occurs equally often in the extended sequence,
  // so AND and OR of neighbours give exact ratios
  always_comb
  begin
    case (actCfg.ratio)
      TPS_RATIO_1_8: onesBit = b0 & b1 & b2;
      TPS_RATIO_1_4: onesBit = b0 & b1;
      TPS_RATIO_3_4: onesBit = b0 | b1;
      TPS_RATIO_7_8: onesBit = b0 | b1 | b2;
      default: onesBit = b0;
    endcase
  end

  // Position 0 is the start of the longest zero run after a load
  wire logic [12:0] pos13 = posCnt[12:0];
  wire logic zrunBit = (pos13 < actCfg.zeroRun) ? 1'b0
                       : (pos13 == actCfg.zeroRun) ? 1'b1
                       : b0;
  wire logic next_s1Bit = tps_is_ones(actCfg.sel) ? onesBit
                          : tps_is_zrun(actCfg.sel) ? zrunBit
                          : b0;

  // User pattern sources
  wire logic actRam = inRange(actCfg.userNum, TPS_RAM_FIRST, TPS_RAM_LAST);
  wire logic [1:0] slot = 2'(actCfg.userNum - 4'h1);
  wire tps_src_e next_s1Src = !tps_is_user(actCfg.sel) ? TPS_SRC_LFSR
                              : actRam ? TPS_SRC_RAM
                              : TPS_SRC_EXT;
  assign extAddr = posCnt[TPS_EXT_AW-1:0];

  tps_pat_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .en(en),
    .wr(memWr),
    .rdAddr({slot, posCnt[TPS_RAM_AW-1:0]}),
    .rdData(memQ)
  );

  wire logic next_refBit = (s1Src == TPS_SRC_RAM) ? memQ
                           : (s1Src == TPS_SRC_EXT) ? extData
                           : s1Bit;

  // Selection state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      actCfg <= TPS_CFG_RESET;
      run <= 1'b0;
      posCnt <= '0;
    end
    else if (en)
    begin
      actCfg <= loadCfg;
      run <= 1'b1;
      posCnt <= next_posCnt;
    end
  end

  // Status
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfgReject <= 1'b0;
      offered <= TPS_MASTER_MASK;
    end
    else if (en)
    begin
      cfgReject <= cfgLoad && !legal;
      offered <= offerNow;
    end
  end

  // Two-stage pipe: memory and external store answer one cycle late
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1Bit <= 1'b0;
      s1Start <= 1'b0;
      s1Valid <= 1'b0;
      s1Src <= TPS_SRC_LFSR;
      s1Pos <= '0;
    end
    else if (en)
    begin
      s1Bit <= next_s1Bit;
      s1Start <= posCnt == '0;
      s1Valid <= run && !restart;
      s1Src <= next_s1Src;
      s1Pos <= pos13;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      refBit <= 1'b0;
      refValid <= 1'b0;
      refStart <= 1'b0;
    end
    else if (en)
    begin
      refBit <= next_refBit;
      refValid <= s1Valid;
      refStart <= s1Valid && s1Start;
    end
  end

  assign activeSel = actCfg.sel;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_take;
    en && cfgLoad && legal;
  endsequence
  sequence s_play;
    en && run && !restart;
  endsequence
  sequence s_zrunPos;
    en && s1Valid && tps_is_zrun(actCfg.sel);
  endsequence

  property p_wrap;
    s_play ##0 wrap |=> posCnt == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("position did not wrap at end of period");

  property p_len7;
    s_play ##0 (actCfg.sel == TPS_PRBS7) |-> lastPos == 31'h0000007e;
  endproperty
  a_len7: assert property (p_len7)
    else $error("short sequence period is not 127");

  property p_user_take;
    s_take ##0 tps_is_user(cfg.sel)
      |=> actCfg.userLen != '0 && actCfg.userLen <= TPS_USER_MAX
      && activeSel == $past(cfg.sel) && !s1Valid;
  endproperty
  a_user_take: assert property (p_user_take)
    else $error("user pattern taken with bad length or not applied");

  property p_ram_len;
    s_take ##0 (tps_is_user(cfg.sel) && numRam)
      |=> actCfg.userLen <= TPS_RAM_MAX;
  endproperty
  a_ram_len: assert property (p_ram_len)
    else $error("RAM pattern longer than 8192 bits taken");

  property p_ext_data;
    (en && s1Valid && s1Src == TPS_SRC_EXT) |=> refBit == $past(extData);
  endproperty
  a_ext_data: assert property (p_ext_data)
    else $error("external pattern bit not passed to the stream");

  property p_zrun_align;
    s_play ##0 (tps_is_zrun(actCfg.sel) && posCnt == '0)
      |-> lfsrState == '0 && lastPos == ((31'h1 << deg) - 31'h1);
  endproperty
  a_zrun_align: assert property (p_zrun_align)
    else $error("zero-run sequence misaligned or wrong length");

  property p_run_zero;
    s_zrunPos ##0 (s1Pos < actCfg.zeroRun) |=> !refBit;
  endproperty
  a_run_zero: assert property (p_run_zero)
    else $error("one inside the substituted zero run");

  property p_run_end;
    s_zrunPos ##0 (s1Pos == actCfg.zeroRun) |=> refBit;
  endproperty
  a_run_end: assert property (p_run_end)
    else $error("bit after the zero run is not one");

  property p_ones_len;
    s_play ##0 tps_is_ones(actCfg.sel) |-> lastPos == (31'h1 << deg) - 31'h1;
  endproperty
  a_ones_len: assert property (p_ones_len)
    else $error("ones-ratio sequence length is not a power of two");

  property p_ratio;
    s_take ##0 tps_is_ones(cfg.sel) |=> actCfg.ratio <= TPS_RATIO_7_8;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("undefined ones ratio taken");

  property p_master_offer;
    (en && !slaveMode) |=> !offered[TPS_ALTWORD] && !offered[TPS_ALTPAT];
  endproperty
  a_master_offer: assert property (p_master_offer)
    else $error("alternate selections offered as master");

  property p_slave_offer;
    (en && slaveMode) |=> offered == $past(companionMask);
  endproperty
  a_slave_offer: assert property (p_slave_offer)
    else $error("slave offer differs from companion");

  property p_reject;
    (en && cfgLoad && !legal) |=> cfgReject && actCfg == $past(actCfg);
  endproperty
  a_reject: assert property (p_reject)
    else $error("illegal selection was not refused");

endmodule : tps_selector

/* verification/tb_test_pattern_selector.sv */
// Self-checking bench of the test pattern selector.
// Assumes a 100 MHz clock and the external store model on the far side.
module tb_test_pattern_selector
  import tps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b1;
  tps_cfg_s cfg = TPS_CFG_RESET;
  logic cfgLoad = 1'b0;
  logic slaveMode = 1'b0;
  tps_selmask_t companionMask = 16'h0000;
  tps_mwr_s memWr = '0;
  logic [TPS_EXT_AW-1:0] extAddr;
  logic extData;
  logic refBit, refValid, refStart, cfgReject;
  tps_selmask_t offered;
  tps_sel_e activeSel;
  int numErrors = 0;
  int checksDone = 0;
  logic bits [0:32767];
  logic rej;
  int nx;

  always #5 clk = ~clk;

  tps_selector dut (.clk(clk), .nrst(nrst), .en(en), .cfg(cfg),
    .cfgLoad(cfgLoad), .slaveMode(slaveMode),
    .companionMask(companionMask), .memWr(memWr), .extAddr(extAddr),
    .extData(extData), .refBit(refBit), .refValid(refValid),
    .refStart(refStart), .cfgReject(cfgReject), .offered(offered),
    .activeSel(activeSel));

  tps_ext_store_model store (.clk(clk), .addr(extAddr), .data(extData));

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string msg);
    checksDone++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, msg,
        seen, exp);
    end
  endtask : check

  task automatic load(input tps_sel_e s, input logic [3:0] num,
    input logic [22:0] len, input logic [12:0] zr, input tps_ratio_e r,
    output logic rj);
    cfg = '{sel: s, userNum: num, userLen: len, zeroRun: zr, ratio: r};
    cfgLoad = 1'b1;
    step();
    rj = cfgReject;
    // An edge passes so back-to-back calls never toggle the strobe twice
    cfgLoad = 1'b0;
    step();
  endtask : load

  // Waits for the new period, then records n bits and the next restart
  task automatic capture(input int n, output int nxt);
    int w;
    w = 0;
    nxt = 0;
    do
    begin
      step();
      w++;
    end while (refStart !== 1'b1 && w < 40);
    check(32'(w < 40), 32'h1, "stream start");
    for (int i = 0; i < n; i++)
    begin
      bits[i] = refBit;
      if (i > 0 && refStart === 1'b1 && nxt == 0)
        nxt = i;
      if (i < n - 1)
        step();
    end
  endtask : capture

  function automatic logic [31:0] ones(input int n);
    int c;
    c = 0;
    for (int i = 0; i < n; i++)
      c += (bits[i] === 1'b1);
    return 32'(c);
  endfunction : ones

  task automatic t_reset();
    check(32'(offered), 32'(TPS_MASTER_MASK), "master offer");
    check(32'(activeSel), 32'(TPS_PRBS31), "reset selection");
    check(32'(refValid), 32'h0, "valid in reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_prbs();
    tps_sel_e ps[3] = '{TPS_PRBS7, TPS_PRBS10, TPS_PRBS15};
    int dg[3] = '{7, 10, 15};
    for (int k = 0; k < 3; k++)
    begin
      load(ps[k], 4'h1, 23'h1, 13'h1, TPS_RATIO_1_2, rej);
      check(32'(rej), 32'h0, "prbs accepted");
      capture(1 << dg[k], nx);
      check(32'(nx), 32'((1 << dg[k]) - 1), "prbs period");
      // A maximal sequence has exactly half rounded up as ones
      check(ones((1 << dg[k]) - 1), 32'(1 << (dg[k] - 1)), "ones");
    end
    load(TPS_PRBS23, 4'h1, 23'h1, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h0, "prbs23 accepted");
    check(32'(activeSel), 32'(TPS_PRBS23), "prbs23 selected");
    $display("test prbs done");
  endtask : t_prbs

  task automatic t_zrun();
    tps_sel_e zs[4] = '{TPS_ZRUN13, TPS_ZRUN11, TPS_ZRUN10, TPS_ZRUN7};
    int dg[4] = '{13, 11, 10, 7};
    for (int k = 0; k < 4; k++)
    begin
      load(zs[k], 4'h1, 23'h1, 13'h0014, TPS_RATIO_1_2, rej);
      check(32'(rej), 32'h0, "zero run accepted");
      capture((1 << dg[k]) + 1, nx);
      check(32'(nx), 32'(1 << dg[k]), "zero run period");
      check(ones(20), 32'h0, "zero run body");
      check(32'(bits[20]), 32'h1, "bit after run");
    end
    load(TPS_ZRUN7, 4'h1, 23'h1, 13'h0080, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h1, "run too long");
    check(32'(refValid), 32'h1, "stream unbroken");
    load(TPS_ZRUN7, 4'h1, 23'h1, 13'h007f, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h0, "longest run");
    capture(128, nx);
    check(ones(127), 32'h0, "longest run body");
    check(32'(bits[127]), 32'h1, "last bit one");
    $display("test zero run done");
  endtask : t_zrun

  task automatic t_ones();
    int want[5] = '{16, 32, 64, 96, 112};
    tps_sel_e os[3] = '{TPS_ONES13, TPS_ONES11, TPS_ONES10};
    int dg[3] = '{13, 11, 10};
    for (int r = 0; r < 5; r++)
    begin
      load(TPS_ONES7, 4'h1, 23'h1, 13'h1, tps_ratio_e'(r), rej);
      check(32'(rej), 32'h0, "ratio accepted");
      capture(129, nx);
      check(32'(nx), 32'h80, "ratio period");
      check(ones(128), 32'(want[r]), "ratio ones");
    end
    for (int k = 0; k < 3; k++)
    begin
      load(os[k], 4'h1, 23'h1, 13'h1, TPS_RATIO_3_4, rej);
      capture((1 << dg[k]) + 1, nx);
      check(32'(nx), 32'(1 << dg[k]), "ratio period");
      check(ones(1 << dg[k]), 32'(3 << (dg[k] - 2)), "ratio ones");
    end
    load(TPS_ONES7, 4'h1, 23'h1, 13'h1, tps_ratio_e'(3'h5), rej);
    check(32'(rej), 32'h1, "bad ratio");
    $display("test ones ratio done");
  endtask : t_ones

  task automatic t_user();
    logic [7:0] pat = 8'hb4;
    for (int i = 0; i < 8; i++)
    begin
      memWr = '{we: 1'b1, slot: 2'h1, addr: 13'(i), data: pat[i]};
      step();
    end
    memWr = '0;
    load(TPS_USER, 4'h2, 23'h000008, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h0, "ram pattern");
    capture(9, nx);
    check(32'(nx), 32'h8, "ram period");
    for (int i = 0; i < 8; i++)
      check(32'(bits[i]), 32'(pat[i]), "ram bit");
    load(TPS_USER, 4'h2, 23'h002001, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h1, "ram too long");
    load(TPS_USER, 4'hd, 23'h000008, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h1, "no pattern 13");
    load(TPS_USER, 4'hc, 23'h400001, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h1, "user too long");
    load(TPS_USER, 4'h4, 23'h002000, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h0, "ram max");
    load(TPS_USER, 4'h5, 23'h400000, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h0, "user max");
    capture(16, nx);
    for (int i = 0; i < 16; i++)
      check(32'(bits[i]), 32'(i[0] ^ i[2]), "disc bit");
    load(TPS_USER, TPS_CURRENT, 23'h00000a, 13'h1, TPS_RATIO_1_2, rej);
    capture(11, nx);
    check(32'(nx), 32'ha, "current period");
    $display("test user done");
  endtask : t_user

  task automatic t_select();
    load(TPS_ALTWORD, 4'h1, 23'h8, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h1, "master alt word");
    load(TPS_ALTPAT, 4'h1, 23'h8, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h1, "master alt pattern");
    slaveMode = 1'b1;
    companionMask = 16'h8021;
    step();
    step();
    check(32'(offered), 32'h8021, "slave offer");
    load(TPS_PRBS7, 4'h1, 23'h8, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h1, "not offered");
    load(TPS_ALTPAT, 4'h1, 23'h8, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h0, "slave alt pattern");
    check(32'(activeSel), 32'(TPS_ALTPAT), "active alt");
    slaveMode = 1'b0;
    step();
    step();
    check(32'(offered), 32'(TPS_MASTER_MASK), "master again");
    $display("test selection done");
  endtask : t_select

  // Clock enable low freezes the stream and ignores requests
  task automatic t_hold();
    logic [TPS_EXT_AW-1:0] a;
    logic b;
    load(TPS_PRBS7, 4'h1, 23'h1, 13'h1, TPS_RATIO_1_2, rej);
    capture(2, nx);
    a = extAddr;
    b = refBit;
    en = 1'b0;
    load(TPS_PRBS10, 4'h1, 23'h1, 13'h1, TPS_RATIO_1_2, rej);
    check(32'(rej), 32'h0, "no answer frozen");
    check(32'(activeSel), 32'(TPS_PRBS7), "frozen selection");
    check(32'(extAddr), 32'(a), "frozen position");
    check(32'(refBit), 32'(b), "frozen bit");
    check(32'(refValid), 32'h1, "frozen valid");
    en = 1'b1;
    step();
    check(32'(extAddr), 32'(a) + 32'h1, "resumed position");
    check(32'(activeSel), 32'(TPS_PRBS7), "request dropped");
    $display("test hold done");
  endtask : t_hold

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    t_reset();
    nrst = 1'b1;
    t_prbs();
    t_zrun();
    t_ones();
    t_user();
    t_select();
    t_hold();
    finish_test();
  end

  // Tests take about 60,000 cycles; a hang ends before 100,000
  initial
  begin
    #950_000;
    numErrors++;
    finish_test();
  end
endmodule : tb_test_pattern_selector

/* verification/tps_ext_store_model.sv */
// External pattern store seen by the selector: one bit per address.
// Assumes the selector presents an address and samples one cycle later.
module tps_ext_store_model
  import tps_pkg::*;
(
  // Clock
  input wire logic clk,
  // Store port
  input wire logic [TPS_EXT_AW-1:0] addr,
  output logic data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Content changes every few addresses so a stale read shows up
  always_ff @(posedge clk)
  begin
    data <= addr[0] ^ addr[2];
  end
  // Sync threshold is set by the operator; no input here
endmodule : tps_ext_store_model
